// [src/cirs_pkg.sv]
package cirs_pkg;
  // Command codes seen on the link
  localparam logic [5:0]   CMD_OP_COND                 = 6'h01;
  localparam logic [5:0]   ASSIGN_ADDRESS_COMMAND_CODE = 6'h03;
  localparam logic [5:0]   CARD_PICK_COMMAND_CODE      = 6'h07;
  localparam logic [5:0]   CMD_SEND_PARAM              = 6'h09;
  localparam logic [5:0]   CMD_SEND_ID                 = 6'h0A;
  localparam logic [5:0]   CMD_PROGRAM_PARAM           = 6'h1B;
  // Address register
  localparam logic [15:0]  RCA_RESET                   = 16'h0001;
  localparam logic [15:0]  RCA_NONE                    = 16'h0000;
  localparam int           ARG_ADDR_LSB                = 16;
  // Operating conditions
  localparam int           OCR_READY_BIT               = 31;
  // Identity checksum
  localparam logic [6:0]   CRC_POLY                    = 7'h09;
  localparam int           ID_BODY_W                   = 120;
  // Parameter record fixed fields, msb first
  localparam logic [1:0]   RECORD_STRUCTURE_VERSION    = 2'h1;
  localparam logic [3:0]   SPEC_VERSION_FIELD          = 4'h2;
  localparam logic [7:0]   ASYNC_ACCESS_TIME_CODE      = 8'h0E;
  localparam logic [7:0]   CLOCKED_ACCESS_FACTOR       = 8'h01;
  localparam logic [7:0]   TRANSFER_RATE_CODE          = 8'h2A;
  localparam logic [11:0]  COMMAND_CLASS_MASK          = 12'h0FF;
  localparam logic [3:0]   READ_BLOCK_LENGTH_CODE      = 4'h9;
  localparam logic [11:0]  DEVICE_SIZE_CODE            = 12'h7A7;
  localparam logic [2:0]   READ_CURRENT_LOW_SUPPLY     = 3'h5;
  localparam logic [2:0]   READ_CURRENT_HIGH_SUPPLY    = 3'h4;
  localparam logic [2:0]   DEVICE_SIZE_MULTIPLIER      = 3'h3;
  localparam logic [4:0]   ERASE_GROUP_CODE            = 5'h0F;
  localparam logic [4:0]   PROTECT_GROUP_CODE          = 5'h01;
  localparam logic [2:0]   WRITE_SPEED_FACTOR          = 3'h2;
  localparam logic [3:0]   WRITE_BLOCK_LENGTH_CODE     = 4'h9;
  localparam logic [111:0] PARAM_FIXED = {
    RECORD_STRUCTURE_VERSION, SPEC_VERSION_FIELD, 2'h0,
    ASYNC_ACCESS_TIME_CODE, CLOCKED_ACCESS_FACTOR, TRANSFER_RATE_CODE,
    COMMAND_CLASS_MASK, READ_BLOCK_LENGTH_CODE,
    1'b1, 1'b0, 1'b0, 1'b0, 2'h0, DEVICE_SIZE_CODE,
    READ_CURRENT_LOW_SUPPLY, READ_CURRENT_HIGH_SUPPLY,
    READ_CURRENT_LOW_SUPPLY, READ_CURRENT_HIGH_SUPPLY,
    DEVICE_SIZE_MULTIPLIER, 5'h00, ERASE_GROUP_CODE, PROTECT_GROUP_CODE,
    1'b1, 2'h0, WRITE_SPEED_FACTOR, WRITE_BLOCK_LENGTH_CODE, 1'b0, 5'h00};
  // User field: record bits 15..1 held as bits 14..0
  localparam int           USER_W                      = 15;
  localparam int           USER_LSB                    = 1;
  localparam int           COPY_IDX                    = 13;
  localparam int           ERASE_FLAG_BIT              = 16;
  localparam logic [14:0]  ERASABLE_MASK               = 15'h09FF;
  // Access code layout
  localparam int           ACC_EXP_MSB                 = 2;
  localparam int           ACC_MANT_MSB                = 6;
  localparam int           ACC_MANT_LSB                = 3;
  localparam logic [15:0]  CLOCKED_ACCESS_FACTOR_UNIT_CLOCKS            = 16'h0064;
  // Answer lengths in bits
  localparam logic [7:0]   LEN_NONE                    = 8'h00;
  localparam logic [7:0]   LEN_SHORT                   = 8'h20;
  localparam logic [7:0]   LEN_LONG                    = 8'h80;
  // Block to block timing
  localparam int           CLK_PERIOD_PS               = 25000;
  localparam int           BLK_FAST_NS                 = 1000;
  localparam int           BLK_SLOW_NS                 = 62000;
  localparam int           BLK_FAST_CYC = BLK_FAST_NS * 1000 / CLK_PERIOD_PS;
  localparam int           BLK_SLOW_CYC = BLK_SLOW_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [11:0]  SMALL_BLOCK_BYTES           = 12'h100;
endpackage : cirs_pkg

// [src/cirs_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cirs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule : cirs_sync
`default_nettype wire

// [src/cirs_crc7.sv]
`timescale 1ns/1ps
`default_nettype none
module cirs_crc7 #(
  parameter int W = cirs_pkg::ID_BODY_W
) (
  // Message, msb first
  input  wire logic [W-1:0] data,
  // Remainder
  output logic      [6:0]   crc
);
  always_comb begin
    logic [6:0] c;
    logic       fb;
    c  = 7'h00;
    fb = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      fb = data[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? cirs_pkg::CRC_POLY : 7'h00);
    end
    crc = c;
  end
endmodule : cirs_crc7
`default_nettype wire

// [src/cirs_card_info.sv]
`timescale 1ns/1ps
`default_nettype none
module cirs_card_info #(
  parameter logic [30:0] OCR_RANGE  = 31'h00FF8000,
  // Identity values are arbitrary
  parameter logic [7:0]  MAKER_CODE = 8'h5A,
  parameter logic [15:0] OEM_CODE   = 16'h1234,
  parameter logic [47:0] PRODUCT_NAME_FIELD = 48'h414243444546,
  parameter logic [7:0]  PRODUCT_REVISION_FIELD = 8'h10,
  parameter logic [31:0] SERIAL_NUMBER_FIELD = 32'h00000001,
  parameter logic [7:0]  BUILD_DATE_FIELD = 8'h11
) (
  // Core clock and power-up reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Mode pin
  input  wire logic        spi_mode_pin,
  // Nonvolatile user field
  input  wire logic [14:0] nv_user_in,
  output logic      [14:0] nv_user_out,
  // Card state
  output logic             card_selected,
  output logic [2:0]       access_time_exp,
  output logic [3:0]       access_time_mant,
  output logic [15:0]      access_clocks,
  // Block to block timing
  input  wire logic        blk_req,
  input  wire logic [11:0] blk_len,
  output logic             blk_ready,
  // Link side
  input  wire logic        link_clk,
  input  wire logic        cmd_valid,
  input  wire logic [5:0]  cmd_code,
  input  wire logic [31:0] cmd_arg,
  output logic             cmd_ready,
  output logic             resp_bit,
  output logic             resp_valid,
  output logic             resp_last
);
  typedef enum logic [1:0] {L_IDLE, L_WAIT, L_SHIFT} cirs_link_e;

  logic [15:0]  relative_bus_address;
  logic         spi_mode, pwr_done, req_sync, req_seen, ack_tgl, ex_go;
  logic [127:0] resp_word, id_record, param_record;
  logic [7:0]   resp_len;
  logic [6:0]   id_crc;
  logic [31:0]  ocr_word;
  logic [15:0]  arg_addr;
  logic [14:0]  next_user;
  logic [11:0]  blk_cnt;
  logic         blk_busy, lrst_n, req_tgl, ack_sync, ack_seen;
  cirs_link_e   lstate;
  logic [5:0]   lk_code;
  logic [31:0]  lk_arg;
  logic [7:0]   sh_cnt;

  // Identity record with checksum
  cirs_crc7 #(.W(cirs_pkg::ID_BODY_W)) u_crc (
    .data ({MAKER_CODE, OEM_CODE, PRODUCT_NAME_FIELD,
            PRODUCT_REVISION_FIELD, SERIAL_NUMBER_FIELD, BUILD_DATE_FIELD}),
    .crc  (id_crc)
  );

  assign id_record = {MAKER_CODE, OEM_CODE, PRODUCT_NAME_FIELD,
                      PRODUCT_REVISION_FIELD, SERIAL_NUMBER_FIELD,
                      BUILD_DATE_FIELD, id_crc, 1'b1};

  assign param_record = {cirs_pkg::PARAM_FIXED, nv_user_out, 1'b1};

  assign ocr_word = {pwr_done, OCR_RANGE};

  // Crossings
  cirs_sync #(.W(1)) u_sync_mode (
    .clock (clock),
    .rst_n (rst_n),
    .d     (spi_mode_pin),
    .q     (spi_mode)
  );
  cirs_sync #(.W(1)) u_sync_req (
    .clock (clock),
    .rst_n (rst_n),
    .d     (req_tgl),
    .q     (req_sync)
  );
  cirs_sync #(.W(1)) u_sync_rst (
    .clock (link_clk),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (lrst_n)
  );
  cirs_sync #(.W(1)) u_sync_ack (
    .clock (link_clk),
    .rst_n (lrst_n),
    .d     (ack_tgl),
    .q     (ack_sync)
  );

  // Command taken in core domain; link regs stay still meanwhile
  assign ex_go    = req_sync != req_seen;
  assign arg_addr = lk_arg[31:cirs_pkg::ARG_ADDR_LSB];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwr_done <= 1'b0;
    end else begin
      pwr_done <= 1'b1;
    end
  end

  // Address register, volatile
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      relative_bus_address <= cirs_pkg::RCA_RESET;
    end else if (ex_go && !spi_mode && arg_addr != cirs_pkg::RCA_NONE &&
                 lk_code == cirs_pkg::ASSIGN_ADDRESS_COMMAND_CODE) begin
      relative_bus_address <= arg_addr;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      card_selected <= 1'b0;
    end else if (ex_go && !spi_mode &&
                 lk_code == cirs_pkg::CARD_PICK_COMMAND_CODE) begin
      card_selected <= arg_addr != cirs_pkg::RCA_NONE &&
                       arg_addr == relative_bus_address;
    end
  end

  // User field: copy one-time, erase clears erasable bits
  always_comb begin
    next_user = lk_arg[cirs_pkg::USER_LSB +: cirs_pkg::USER_W];
    next_user[cirs_pkg::COPY_IDX] = next_user[cirs_pkg::COPY_IDX] |
                                    nv_user_out[cirs_pkg::COPY_IDX];
    if (lk_arg[cirs_pkg::ERASE_FLAG_BIT]) begin
      next_user = nv_user_out & ~cirs_pkg::ERASABLE_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nv_user_out <= nv_user_in;
    end else if (ex_go && lk_code == cirs_pkg::CMD_PROGRAM_PARAM) begin
      nv_user_out <= next_user;
    end
  end

  // Answer build
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resp_word <= '0;
      resp_len  <= cirs_pkg::LEN_NONE;
    end else if (ex_go) begin
      resp_word <= '0;
      resp_len  <= cirs_pkg::LEN_NONE;
      case (lk_code)
        cirs_pkg::CMD_OP_COND: begin
          resp_word[127:96] <= ocr_word;
          resp_len          <= cirs_pkg::LEN_SHORT;
        end
        cirs_pkg::ASSIGN_ADDRESS_COMMAND_CODE,
        cirs_pkg::CARD_PICK_COMMAND_CODE: begin
          if (!spi_mode) begin
            // Echo code only, address itself never sent
            resp_word[101:96] <= lk_code;
            resp_len          <= cirs_pkg::LEN_SHORT;
          end
        end
        cirs_pkg::CMD_SEND_PARAM: begin
          if (spi_mode || arg_addr == relative_bus_address) begin
            resp_word <= param_record;
            resp_len  <= cirs_pkg::LEN_LONG;
          end
        end
        cirs_pkg::CMD_SEND_ID: begin
          if (spi_mode || arg_addr == relative_bus_address) begin
            resp_word <= id_record;
            resp_len  <= cirs_pkg::LEN_LONG;
          end
        end
        cirs_pkg::CMD_PROGRAM_PARAM: begin
          resp_word[101:96] <= lk_code;
          resp_len          <= cirs_pkg::LEN_SHORT;
        end
        default: begin
          resp_len <= cirs_pkg::LEN_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
    end else if (ex_go) begin
      req_seen <= req_sync;
      ack_tgl  <= ~ack_tgl;
    end
  end

  // Access time decode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      access_time_exp  <= 3'h0;
      access_time_mant <= 4'h0;
      access_clocks    <= 16'h0000;
    end else begin
      access_time_exp  <= cirs_pkg::ASYNC_ACCESS_TIME_CODE[
                            cirs_pkg::ACC_EXP_MSB:0];
      access_time_mant <= cirs_pkg::ASYNC_ACCESS_TIME_CODE[
                            cirs_pkg::ACC_MANT_MSB:
                            cirs_pkg::ACC_MANT_LSB];
      access_clocks    <= 16'(cirs_pkg::CLOCKED_ACCESS_FACTOR_UNIT_CLOCKS *
                              {8'h00, cirs_pkg::CLOCKED_ACCESS_FACTOR});
    end
  end

  // Block to block timer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blk_busy <= 1'b0;
      blk_cnt  <= 12'h000;
    end else if (!blk_busy) begin
      if (blk_req) begin
        blk_busy <= 1'b1;
        blk_cnt  <= (blk_len < cirs_pkg::SMALL_BLOCK_BYTES) ?
                    12'(cirs_pkg::BLK_SLOW_CYC - 1) :
                    12'(cirs_pkg::BLK_FAST_CYC - 1);
      end
    end else if (blk_cnt == 12'h000) begin
      blk_busy <= 1'b0;
    end else begin
      blk_cnt <= blk_cnt - 12'h001;
    end
  end

  assign blk_ready = blk_busy && blk_cnt == 12'h000;

  // Link side
  assign cmd_ready = lstate == L_IDLE;

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      lstate     <= L_IDLE;
      req_tgl    <= 1'b0;
      ack_seen   <= 1'b0;
      lk_code    <= 6'h00;
      lk_arg     <= 32'h00000000;
      sh_cnt     <= 8'h00;
      resp_bit   <= 1'b0;
      resp_valid <= 1'b0;
      resp_last  <= 1'b0;
    end else begin
      case (lstate)
        L_IDLE: begin
          if (cmd_valid) begin
            lk_code <= cmd_code;
            lk_arg  <= cmd_arg;
            req_tgl <= ~req_tgl;
            lstate  <= L_WAIT;
          end
        end
        L_WAIT: begin
          if (ack_sync != ack_seen) begin
            ack_seen <= ack_sync;
            sh_cnt   <= 8'h00;
            lstate   <= (resp_len == cirs_pkg::LEN_NONE) ? L_IDLE : L_SHIFT;
          end
        end
        L_SHIFT: begin
          if (sh_cnt == resp_len) begin
            resp_valid <= 1'b0;
            resp_last  <= 1'b0;
            lstate     <= L_IDLE;
          end else begin
            resp_bit   <= resp_word[~sh_cnt[6:0]];
            resp_valid <= 1'b1;
            resp_last  <= sh_cnt == resp_len - 8'h01;
            sh_cnt     <= sh_cnt + 8'h01;
          end
        end
        default: begin
          lstate <= L_IDLE;
        end
      endcase
    end
  end

  // Checks
  sequence s_exec(logic [5:0] c);
    ex_go && lk_code == c;
  endsequence
  sequence s_assign_ok;
    s_exec(cirs_pkg::ASSIGN_ADDRESS_COMMAND_CODE) ##0
    (!spi_mode && arg_addr != cirs_pkg::RCA_NONE);
  endsequence

  AST_RCA_RESET: assert property (@(posedge clock)
    !rst_n |=> relative_bus_address == cirs_pkg::RCA_RESET)
    else $error("Address not default after reset");
  AST_RCA_NEVER_ZERO: assert property (@(posedge clock)
    disable iff (!rst_n) relative_bus_address != cirs_pkg::RCA_NONE)
    else $error("Address became zero");
  AST_PICK_ZERO: assert property (@(posedge clock)
    disable iff (!rst_n)
    s_exec(cirs_pkg::CARD_PICK_COMMAND_CODE) ##0
    (!spi_mode && arg_addr == cirs_pkg::RCA_NONE) |=> !card_selected)
    else $error("Pick with zero left card selected");
  AST_ASSIGN_STORE: assert property (@(posedge clock)
    disable iff (!rst_n)
    s_assign_ok |=> relative_bus_address == $past(arg_addr) ##1 ack_tgl != $past(ack_tgl, 2))
    else $error("Assigned address not stored or not answered");
  AST_SPI_NO_ADDR: assert property (@(posedge clock)
    disable iff (!rst_n)
    s_exec(cirs_pkg::ASSIGN_ADDRESS_COMMAND_CODE) ##0 spi_mode |=>
    $stable(relative_bus_address) && resp_len == cirs_pkg::LEN_NONE)
    else $error("Address touched in SPI mode");
  AST_OCR_READY: assert property (@(posedge clock)
    disable iff (!rst_n) $rose(rst_n) ##1 1'b1 |-> ocr_word[31])
    else $error("Ready bit not set after reset");
  AST_COPY_ONCE: assert property (@(posedge clock)
    disable iff (!rst_n)
    nv_user_out[cirs_pkg::COPY_IDX] |=> nv_user_out[cirs_pkg::COPY_IDX])
    else $error("Copy flag cleared");
  AST_ID_TAIL: assert property (@(posedge clock)
    disable iff (!rst_n)
    s_exec(cirs_pkg::CMD_SEND_ID) ##0 spi_mode |=>
    resp_word[0] && resp_word[7:1] == id_crc && resp_len == 8'h80)
    else $error("Identity answer tail wrong");
  AST_BLK_FAST: assert property (@(posedge clock)
    disable iff (!rst_n)
    blk_req && !blk_busy && blk_len >= 12'h100 |-> ##40 blk_ready)
    else $error("Fast block gap not 40 cycles");
  AST_MSB_FIRST: assert property (@(posedge link_clk)
    disable iff (!lrst_n)
    $rose(resp_valid) |-> resp_bit == resp_word[127])
    else $error("First answer bit not msb");
endmodule : cirs_card_info
`default_nettype wire

// [tb/cirs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cirs_host_model (
  // Link clock and card answer
  input  wire logic        link_clk,
  input  wire logic        cmd_ready,
  input  wire logic        resp_bit,
  input  wire logic        resp_valid,
  input  wire logic        resp_last,
  // Bench side
  input  wire logic        req_t,
  input  wire logic [5:0]  code,
  input  wire logic [31:0] arg,
  output logic             done,
  output logic [127:0]     answer,
  output logic [7:0]       nbits,
  // Command to card
  output logic             cmd_valid,
  output logic [5:0]       cmd_code,
  output logic [31:0]      cmd_arg
);
  logic       seen_t = 1'b0;
  logic       busy   = 1'b0;
  logic [7:0] waited = 8'h00;
  initial begin
    done      = 1'b1;
    answer    = 128'h0;
    nbits     = 8'h00;
    cmd_valid = 1'b0;
    cmd_code  = 6'h3F;
    cmd_arg   = 32'hFFFFFFFF;
  end
  // One command at a time, held until taken
  always @(posedge link_clk) begin
    if (!busy && req_t != seen_t) begin
      seen_t    <= req_t;
      busy      <= 1'b1;
      done      <= 1'b0;
      nbits     <= 8'h00;
      waited    <= 8'h00;
      cmd_valid <= 1'b1;
      cmd_code  <= code;
      cmd_arg   <= arg;
    end else if (cmd_valid && cmd_ready) begin
      cmd_valid <= 1'b0;
      cmd_code  <= ~cmd_code;
      cmd_arg   <= ~cmd_arg;
    end else if (busy && !cmd_valid) begin
      waited <= waited + 8'h01;
      if (resp_valid) begin
        answer <= {answer[126:0], resp_bit};
        nbits  <= nbits + 8'h01;
      end
      if ((resp_valid && resp_last) ||
          (waited == 8'h3C && nbits == 8'h00)) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : cirs_host_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [119:0] ID_BODY = {8'hC3, 16'h7E21, 48'h4D4E4F505152,
    8'h21, 32'h0000BEEF, 8'h47};
  localparam logic [30:0]  RANGE   = 31'h00FF8000;
  localparam logic [31:0]  A1      = 32'h00010000;
  logic         clock = 1'b0;
  logic         link_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         spi_mode_pin = 1'b0;
  logic         blk_req = 1'b0;
  logic [11:0]  blk_len = 12'h000;
  logic         req_t = 1'b0;
  logic [5:0]   code = 6'h00;
  logic [31:0]  arg = 32'h0;
  logic [14:0]  nv_mem = 15'h1234;
  logic [14:0]  nv_user_out;
  logic         card_selected, blk_ready, cmd_valid, cmd_ready, done;
  logic         resp_bit, resp_valid, resp_last;
  logic [2:0]   access_time_exp;
  logic [3:0]   access_time_mant;
  logic [15:0]  access_clocks;
  logic [5:0]   cmd_code;
  logic [31:0]  cmd_arg;
  logic [127:0] answer, id;
  logic [7:0]   nbits;
  int           fail_count = 0;
  int           total_checks = 0;
  int           cycles = 0;

  initial forever #12.5 clock = ~clock;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  cirs_card_info #(.OCR_RANGE(RANGE), .MAKER_CODE(ID_BODY[119:112]),
    .OEM_CODE(ID_BODY[111:96]), .PRODUCT_NAME_FIELD(ID_BODY[95:48]),
    .PRODUCT_REVISION_FIELD(ID_BODY[47:40]),
    .SERIAL_NUMBER_FIELD(ID_BODY[39:8]),
    .BUILD_DATE_FIELD(ID_BODY[7:0])) cirs_card_info_inst (
    .clock(clock), .rst_n(rst_n), .spi_mode_pin(spi_mode_pin),
    .nv_user_in(nv_mem), .nv_user_out(nv_user_out),
    .card_selected(card_selected), .access_time_exp(access_time_exp),
    .access_time_mant(access_time_mant), .access_clocks(access_clocks),
    .blk_req(blk_req), .blk_len(blk_len), .blk_ready(blk_ready),
    .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .resp_bit(resp_bit),
    .resp_valid(resp_valid), .resp_last(resp_last));

  cirs_host_model cirs_host_model_inst (
    .link_clk(link_clk), .cmd_ready(cmd_ready), .resp_bit(resp_bit),
    .resp_valid(resp_valid), .resp_last(resp_last), .req_t(req_t),
    .code(code), .arg(arg), .done(done), .answer(answer), .nbits(nbits),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg));

  // Nonvolatile storage of the user field
  always @(posedge clock) begin
    if (rst_n) nv_mem <= nv_user_out;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("BAD %0t run too long", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [127:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [6:0] crc7(input logic [119:0] m);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  function automatic logic [127:0] prec(input logic [14:0] u);
    return {2'h1, 4'h2, 2'h0, 8'h0E, 8'h01, 8'h2A, 12'h0FF, 4'h9, 4'h8,
      2'h0, 12'h7A7, 3'h5, 3'h4, 3'h5, 3'h4, 3'h3, 5'h00, 5'h0F, 5'h01,
      1'b1, 2'h0, 3'h2, 4'h9, 1'b0, 5'h00, u, 1'b1};
  endfunction : prec

  // Command, wait for answer, compare length and bits
  task automatic rd(input logic [5:0] c, input logic [31:0] a,
                    input logic [127:0] exp, input logic [7:0] len,
                    input string what);
    int k;
    @(posedge link_clk);
    code  <= c;
    arg   <= a;
    req_t <= ~req_t;
    repeat (3) @(posedge link_clk);
    for (k = 0; k < 400 && done !== 1'b1; k++) @(posedge link_clk);
    chk(done, 1'b1, what);
    repeat (4) @(posedge clock);
    chk(nbits, len, what);
    if (len != 8'h00) chk(answer & ((128'h1 << len) - 128'h1), exp, what);
  endtask : rd

  task automatic blk(input logic [11:0] len, input int exp);
    int n;
    @(posedge clock);
    blk_len <= len;
    blk_req <= 1'b1;
    for (n = 0; n < 3000; ) begin
      @(posedge clock);
      n++;
      blk_req <= 1'b0;
      #1;
      if (blk_ready === 1'b1) break;
    end
    chk(128'(n), 128'(exp), "block gap");
  endtask : blk

  task automatic powerup();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
  endtask : powerup

  initial begin
    id = {ID_BODY, crc7(ID_BODY), 1'b1};
    powerup();
    rd(6'h01, 32'h0, {96'h0, 1'b1, RANGE}, 8'h20, "opcond");
    rd(6'h05, 32'h0, 128'h0, 8'h00, "unknown");
    rd(6'h0A, A1, id, 8'h80, "ident");
    rd(6'h09, A1, prec(15'h1234), 8'h80, "param");
    chk(answer, prec(15'h1234), "param");
    chk(access_time_exp, 3'h6, "exp");
    chk(access_time_mant, 4'h1, "mant");
    chk(access_clocks, 16'h0064, "clocks");
    $display("test records done");
    rd(6'h03, 32'h0, {122'h0, 6'h03}, 8'h20, "assign 0");
    rd(6'h0A, 32'h00010000, id, 8'h80, "kept");
    rd(6'h03, 32'h00A50000, {122'h0, 6'h03}, 8'h20, "assign");
    rd(6'h0A, 32'h00010000, id, 8'h00, "old addr");
    rd(6'h07, 32'h00A50000, {122'h0, 6'h07}, 8'h20, "pick");
    chk(card_selected, 1'b1, "sel");
    rd(6'h07, 32'h0, {122'h0, 6'h07}, 8'h20, "pick 0");
    chk(card_selected, 1'b0, "desel");
    $display("test address done");
    rd(6'h1B, 32'h0000FFFE, {122'h0, 6'h1B}, 8'h20, "prog");
    rd(6'h09, 32'h00A50000, prec(15'h7FFF), 8'h80, "p1");
    rd(6'h1B, 32'h00009EAA, {122'h0, 6'h1B}, 8'h20, "prog");
    rd(6'h09, 32'h00A50000, prec(15'h6F55), 8'h80, "copy");
    rd(6'h1B, 32'h00010000, {122'h0, 6'h1B}, 8'h20, "erase");
    rd(6'h09, 32'h00A50000, prec(15'h6600), 8'h80, "erased");
    $display("test user bits done");
    powerup();
    chk(card_selected, 1'b0, "sel off");
    rd(6'h0A, 32'h00010000, id, 8'h80, "addr lost");
    rd(6'h09, 32'h00010000, prec(15'h6600), 8'h80, "kept");
    $display("test power loss done");
    @(posedge clock);
    spi_mode_pin <= 1'b1;
    repeat (4) @(posedge clock);
    rd(6'h0A, 32'hFFFF0000, id, 8'h80, "spi id");
    rd(6'h09, 32'h0, prec(15'h6600), 8'h80, "spi par");
    rd(6'h03, 32'h00330000, 128'h0, 8'h00, "spi asg");
    rd(6'h01, 32'h0, {96'h0, 1'b1, RANGE}, 8'h20, "spi oc");
    $display("test spi done");
    blk(12'h200, 40);
    blk(12'h100, 40);
    blk(12'h0FF, 2480);
    $display("test block gap done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
